// file: hw/cdac_regs.vh
// Register offsets, field positions, reset values and codes for the current DAC control block.
`ifndef CDAC_REGS_VH
`define CDAC_REGS_VH
`define CDAC_ADDR_W          8
`define CDAC_ADDR_CONTROL    8'hB9
`define CDAC_ADDR_DATA_HIGH  8'h97
`define CDAC_ADDR_DATA_LOW   8'h96
`define CDAC_CTL_EN_BIT      7
`define CDAC_CTL_SRC_HI      6
`define CDAC_CTL_SRC_LO      4
`define CDAC_CTL_RANGE_HI    1
`define CDAC_CTL_RANGE_LO    0
`define CDAC_CTL_RESET       8'h72
`define CDAC_DATA_RESET      8'h00
`define CDAC_LOW_MASK        8'hC0
`define CDAC_CTL_MASK        8'hF3
`define CDAC_SRC_TIMER3      3'h3
`define CDAC_SRC_RISE        3'h4
`define CDAC_SRC_FALL        3'h5
`define CDAC_SRC_ANY         3'h6
`define CDAC_SRC_WRITE       3'h7
`define CDAC_RANGE_0P5MA     2'h0
`define CDAC_RANGE_1MA       2'h1
`define CDAC_RANGE_2MA       2'h2
`define CDAC_SYNC_STAGES     2
`endif

// file: hw/cdac_sync.v
// Two-stage synchroniser for the external convert strobe.
module cdac_sync (
	// Clock and reset
	input  wire clk_sys,
	input  wire rst,
	// Signal
	input  wire din,
	output reg  dout
);
	reg stage1;

	always @(posedge clk_sys) begin
		if (rst) begin
			stage1 <= 1'b0;
			dout   <= 1'b0;
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule // cdac_sync

// file: hw/cdac_top.v
// Control logic of the 10-bit current-output DAC: registers, update scheduling and output latches.
// Functional notes
// - Disabled: pin stays ordinary GPIO.
// - Enabled: pin driver, pull-up off, output connected.
// - Bias generator enabled whenever converter enabled.
// - Source 111: high byte write loads latches.
// - Low byte write alone only stored.
// - Sources 000-011: timer 0-3 overflow loads.
// - Sources 100-110: strobe rise, fall, any.
// - Selected edge copies high:low into latches.
// - Word left-justified: high 7:0, low 7:6.
// - Range field, default 2 mA.
// - 00 0.5 mA, 01 1 mA, 1x 2 mA.
`include "cdac_regs.vh"
module cdac_top #(
	parameter DATA_W = 10
) (
	// Clock and reset
	input  wire                    clk_sys,
	input  wire                    rst,
	// Register port
	input  wire [`CDAC_ADDR_W-1:0] reg_addr,
	input  wire                    reg_wr,
	input  wire                    reg_rd,
	input  wire [7:0]              reg_wdata,
	output reg  [7:0]              reg_rdata,
	// Update sources
	input  wire [3:0]              timer_ovf,
	input  wire                    ext_convert_strobe,
	// Analog side
	output reg  [DATA_W-1:0]       dac_code,
	output reg  [1:0]              fullscale_range_select,
	output reg                     pin_analog_connect,
	output reg                     pin_digital_disable,
	output reg                     bias_enable
);
	localparam ST_IDLE    = 2'b01;
	localparam ST_LOAD    = 2'b10;
	localparam NUM_TIMERS = 4;

	reg  [7:0]                 dac_control;
	reg  [7:0]                 dac_data_high;
	reg  [7:0]                 dac_data_low;
	reg  [7:0]                 next_reg_rdata;
	reg  [1:0]                 next_range;

	reg  [1:0]                 state;
	reg  [1:0]                 next_state;
	reg                        strobe_prev;
	reg  [`CDAC_SYNC_STAGES:0] strobe_fill;
	reg                        edge_now;
	wire                       strobe_sync;
	wire                       rise;
	wire                       fall;
	wire [NUM_TIMERS-1:0]      timer_sel;
	wire                       timer_now;
	wire                       write_now;
	wire                       update_now;
	wire [DATA_W-1:0]          latch_word;

	wire                       wr_ctl;
	wire                       wr_high;
	wire                       wr_low;
	wire                       dac_enable;
	wire [2:0]                 update_source_select;
	wire [1:0]                 range_field;
	wire [7:0]                 source_onehot;

	assign wr_ctl               = reg_wr && (reg_addr == `CDAC_ADDR_CONTROL);
	assign wr_high              = reg_wr && (reg_addr == `CDAC_ADDR_DATA_HIGH);
	assign wr_low               = reg_wr && (reg_addr == `CDAC_ADDR_DATA_LOW);
	assign dac_enable           = dac_control[`CDAC_CTL_EN_BIT];
	assign update_source_select = dac_control[`CDAC_CTL_SRC_HI:`CDAC_CTL_SRC_LO];
	assign range_field          = dac_control[`CDAC_CTL_RANGE_HI:`CDAC_CTL_RANGE_LO];
	assign source_onehot        = 8'h01 << update_source_select;
	assign latch_word           = {dac_data_high, dac_data_low[7:6]};

	cdac_sync u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (ext_convert_strobe),
		.dout    (strobe_sync)
	);

	// After reset, edges count only once the synchroniser and the previous-level flop hold the real pin level.
	always @(posedge clk_sys) begin
		if (rst) begin
			strobe_prev <= 1'b0;
			strobe_fill <= {(`CDAC_SYNC_STAGES+1){1'b0}};
		end else begin
			strobe_prev <= strobe_sync;
			strobe_fill <= {strobe_fill[`CDAC_SYNC_STAGES-1:0], 1'b1};
		end
	end

	assign rise = strobe_fill[`CDAC_SYNC_STAGES] & strobe_sync & ~strobe_prev;
	assign fall = strobe_fill[`CDAC_SYNC_STAGES] & ~strobe_sync & strobe_prev;

	// Only the timer named by the source field may load the latches.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_TIMERS; gi = gi + 1) begin : gen_timer
			assign timer_sel[gi] = source_onehot[gi] & timer_ovf[gi];
		end
	endgenerate

	assign timer_now  = |timer_sel;
	assign write_now  = source_onehot[`CDAC_SRC_WRITE] & wr_high;
	assign update_now = timer_now | write_now | edge_now;

	always @* begin
		edge_now = 1'b0;
		case (update_source_select)
			`CDAC_SRC_RISE: edge_now = rise;
			`CDAC_SRC_FALL: edge_now = fall;
			`CDAC_SRC_ANY:  edge_now = rise | fall;
			default:        edge_now = 1'b0;
		endcase
	end

	// Unused bits are dropped on write so they read back as zero.
	always @(posedge clk_sys) begin
		if (rst) begin
			dac_control <= `CDAC_CTL_RESET;
		end else if (wr_ctl) begin
			dac_control <= reg_wdata & `CDAC_CTL_MASK;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			dac_data_high <= `CDAC_DATA_RESET;
		end else if (wr_high) begin
			dac_data_high <= reg_wdata;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			dac_data_low <= `CDAC_DATA_RESET;
		end else if (wr_low) begin
			dac_data_low <= reg_wdata & `CDAC_LOW_MASK;
		end
	end

	// Events pass through the state register, so a load always sees the data written with its trigger.
	always @* begin
		case (state)
			ST_IDLE: next_state = update_now ? ST_LOAD : ST_IDLE;
			ST_LOAD: next_state = update_now ? ST_LOAD : ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			dac_code <= {DATA_W{1'b0}};
		end else if (state == ST_LOAD) begin
			dac_code <= latch_word;
		end
	end

	// Range code 11 is folded onto 2 mA so the analog side sees three values only.
	always @* begin
		case (range_field)
			`CDAC_RANGE_0P5MA: next_range = `CDAC_RANGE_0P5MA;
			`CDAC_RANGE_1MA:   next_range = `CDAC_RANGE_1MA;
			default:           next_range = `CDAC_RANGE_2MA;
		endcase
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			fullscale_range_select <= `CDAC_RANGE_2MA;
		end else begin
			fullscale_range_select <= next_range;
		end
	end

	// Pin steering and bias follow the enable bit with no further software action.
	always @(posedge clk_sys) begin
		if (rst) begin
			pin_analog_connect  <= 1'b0;
			pin_digital_disable <= 1'b0;
			bias_enable         <= 1'b0;
		end else begin
			pin_analog_connect  <= dac_enable;
			pin_digital_disable <= dac_enable;
			bias_enable         <= dac_enable;
		end
	end

	always @* begin
		case (reg_addr)
			`CDAC_ADDR_CONTROL:   next_reg_rdata = dac_control;
			`CDAC_ADDR_DATA_HIGH: next_reg_rdata = dac_data_high;
			`CDAC_ADDR_DATA_LOW:  next_reg_rdata = dac_data_low;
			default:              next_reg_rdata = 8'h00;
		endcase
	end

	// Read data holds until the next read, so software may pick it up late.
	always @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_reg_rdata;
		end
	end
endmodule // cdac_top

// file: verif/cdac_monitor.sv
// Checker bound to the current DAC control block.
module cdac_monitor #(parameter DATA_W = 10) (
	// Clock and reset.
	input wire logic              clk_sys,
	input wire logic              rst,
	// Register port.
	input wire logic [7:0]        reg_addr,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [7:0]        reg_wdata,
	input wire logic [7:0]        reg_rdata,
	// Update sources.
	input wire logic [3:0]        timer_ovf,
	input wire logic              ext_convert_strobe,
	// Analog side.
	input wire logic [DATA_W-1:0] dac_code,
	input wire logic [1:0]        fullscale_range_select,
	input wire logic              pin_analog_connect,
	input wire logic              pin_digital_disable,
	input wire logic              bias_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] src;
	logic [7:0] hi, lo;
	wire cw = reg_wr && reg_addr == 8'hb9;
	wire [9:0] nw = {hi, lo[7:6]};
	// Shadow copies, so that load checks do not depend on read-back.
	always @(posedge clk_sys) begin
		src <= rst ? 3'h7 : cw ? reg_wdata[6:4] : src;
		hi <= rst ? 8'h00 : reg_wr && reg_addr == 8'h97 ? reg_wdata : hi;
		lo <= rst ? 8'h00 : reg_wr && reg_addr == 8'h96 ? reg_wdata : lo;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_ENABLE: assert property (cw |-> ##2 pin_analog_connect == $past(reg_wdata[7], 2))
		else $error("enable");
	AST_PIN_BIAS: assert property (pin_digital_disable == pin_analog_connect && bias_enable == pin_analog_connect)
		else $error("pin bias");
	AST_RANGE: assert property (cw |-> ##2 fullscale_range_select ==
		($past(reg_wdata[1], 2) ? 2'h2 : {1'b0, $past(reg_wdata[0], 2)})) else $error("range");
	AST_WR_LOAD: assert property (src == 3'h7 && reg_wr && reg_addr == 8'h97 |-> ##2 dac_code == nw)
		else $error("write load");
	AST_LOW_HOLD: assert property (src == 3'h7 && $changed(dac_code) |-> $past(reg_wr && reg_addr == 8'h97, 2))
		else $error("stray load");
	AST_TMR_LOAD: assert property (src < 3'h4 && timer_ovf[src[1:0]] |-> ##2 dac_code == nw)
		else $error("timer load");
	AST_TMR_HOLD: assert property (src < 3'h4 && $changed(dac_code) |-> $past(timer_ovf[src[1:0]], 2))
		else $error("timer hold");
	AST_STROBE: assert property (src == 3'h4 && $rose(ext_convert_strobe) |-> ##[2:6] dac_code == nw)
		else $error("strobe load");
	cover property (src == 3'h5 && $fell(ext_convert_strobe));
	cover property (src == 3'h6 && $rose(ext_convert_strobe));
	cover property (src == 3'h2 && timer_ovf[2]);
endmodule // cdac_monitor
bind cdac_top cdac_monitor #(.DATA_W(DATA_W)) mon_u (
	.clk_sys                (clk_sys),
	.rst                    (rst),
	.reg_addr               (reg_addr),
	.reg_wr                 (reg_wr),
	.reg_rd                 (reg_rd),
	.reg_wdata              (reg_wdata),
	.reg_rdata              (reg_rdata),
	.timer_ovf              (timer_ovf),
	.ext_convert_strobe     (ext_convert_strobe),
	.dac_code               (dac_code),
	.fullscale_range_select (fullscale_range_select),
	.pin_analog_connect     (pin_analog_connect),
	.pin_digital_disable    (pin_digital_disable),
	.bias_enable            (bias_enable)
);

// file: verif/cdac_strobe_src.sv
// Far-side model: the external strobe pin, lagging the bench request by an off-grid delay.
module cdac_strobe_src (
	// Request and pin.
	input wire logic want,
	output logic     ext_convert_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial ext_convert_strobe = 1'b0;
	// The pin holds its level between edges, as a real strobe source does.
	always @(want) ext_convert_strobe <= #3.7 want;
endmodule // cdac_strobe_src

// file: verif/testbench.sv
// Self-checking bench for the current DAC control block.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, want = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, port0_crossbar_skip = 0;
	logic [3:0] timer_ovf = 0;
	wire [7:0] reg_rdata;
	wire [9:0] dac_code;
	wire [1:0] fullscale_range_select;
	wire pin_analog_connect, pin_digital_disable, bias_enable, ext_convert_strobe;
	int err_count = 0, checked = 0, hi = 0, lo = 0, cur = 0, m = 7;
	cdac_top dut_u (
		.clk_sys                (clk_sys),
		.rst                    (rst),
		.reg_addr               (reg_addr),
		.reg_wr                 (reg_wr),
		.reg_rd                 (reg_rd),
		.reg_wdata              (reg_wdata),
		.reg_rdata              (reg_rdata),
		.timer_ovf              (timer_ovf),
		.ext_convert_strobe     (ext_convert_strobe),
		.dac_code               (dac_code),
		.fullscale_range_select (fullscale_range_select),
		.pin_analog_connect     (pin_analog_connect),
		.pin_digital_disable    (pin_digital_disable),
		.bias_enable            (bias_enable)
	);
	cdac_strobe_src far_u (
		.want               (want),
		.ext_convert_strobe (ext_convert_strobe)
	);
	initial forever #5 clk_sys = ~clk_sys;
	task chk(input logic [9:0] got, input int e);
		checked++;
		if (got !== e[9:0]) begin
			err_count++;
			$display("Error at %0t: got %h, expected %h", $time, got, e[9:0]);
		end
	endtask
	task give_verdict;
		$display("Mismatches %0d, comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// One register access; the model follows each write.
	task acc(input logic w, input logic [7:0] a, d);
		cyc(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		cyc(1);
		reg_wr = 0;
		reg_rd = 0;
		if (w && a == 8'hb9) m = d[6:4];
		if (w && a == 8'h96) lo = d & 8'hc0;
		if (w && a == 8'h97) hi = d;
		if (w && a == 8'h97 && m == 7) cur = hi * 4 + lo / 64;
	endtask
	task fire(input logic ld);
		if (ld) cur = hi * 4 + lo / 64;
		cyc(8);
		chk(dac_code, cur);
	endtask
	initial begin
		void'($urandom(32'h1b46_86e0));
		cyc(12);
		rst = 0;
		acc(0, 8'hb9, 0);
		chk(reg_rdata, 8'h72);
		chk({pin_analog_connect, pin_digital_disable, bias_enable}, 0);
		acc(1, 8'h96, 0);
		repeat (3) begin
			acc(1, 8'h97, 8'($urandom));
			fire(0);
		end
		acc(1, 8'h96, 8'($urandom));
		fire(0);
		acc(1, 8'h97, 8'($urandom));
		fire(0);
		acc(0, 8'h96, 0);
		chk(reg_rdata, lo);
		acc(1, 8'h55, 8'hff);
		acc(0, 8'h55, 0);
		chk(reg_rdata, 0);
		port0_crossbar_skip[1] = 1'b1;
		for (int i = 0; i < 8; i++) begin
			acc(1, 8'hb9, {i[2], 3'h7, 2'h3, i[1:0]});
			acc(0, 8'hb9, 0);
			chk(reg_rdata, {i[2], 3'h7, 2'h0, i[1:0]});
			chk(fullscale_range_select, i[1] ? 2 : i[0]);
			chk({pin_analog_connect, pin_digital_disable, bias_enable}, i[2] ? 7 : 0);
			chk(pin_analog_connect & ~port0_crossbar_skip[1], 0);
		end
		for (int t = 0; t < 4; t++) begin
			acc(1, 8'hb9, {1'b1, t[2:0], 4'h2});
			acc(1, 8'h96, 8'($urandom));
			acc(1, 8'h97, 8'($urandom));
			fire(0);
			timer_ovf = 4'h1 << ((t + 1) % 4);
			cyc(1);
			timer_ovf = 0;
			fire(0);
			timer_ovf = 4'h1 << t;
			cyc(1);
			timer_ovf = 0;
			fire(1);
		end
		for (int s = 4; s < 7; s++) begin
			acc(1, 8'hb9, {1'b1, s[2:0], 4'h2});
			repeat (2) begin
				acc(1, 8'h96, 8'($urandom));
				acc(1, 8'h97, 8'($urandom));
				want = !want;
				fire(s == 6 || want == (s == 4));
			end
		end
		give_verdict;
	end
endmodule // testbench
